// File: rtl/eei_event_flags.sv
// External event flag collector with Wishbone register port.
// Assumes a classic Wishbone master on clk; event inputs may be
// asynchronous and are synchronised here.
`timescale 1ns/1ps
module eei_event_flags
	import eei_pkg::*;
#(
	parameter int DISC_CYC = eei_pkg::EEI_DISC_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Wishbone slave
	input wire eei_pkg::eei_wb_req_t wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Event sources
	input wire eei_pkg::eei_src_t src,
	// Pin function outputs
	output logic [1:0] pin_irq_alt_en,
	output logic rst_pin_fn_en,
	// Interrupt to the core
	output logic irq
);
	import eei_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] byte_mask(input logic [3:0] sel);
		byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// Register select: low byte offset with the upper address bits clear
	function automatic logic reg_hit(input logic [31:0] adr,
			input logic [7:0] off);
		reg_hit = (adr[31:8] == 24'h000000) && (adr[7:0] == off);
	endfunction

	function automatic logic pin_trigger(input logic en, input logic typ,
			input logic pol, input logic lvl, input logic r,
			input logic f);
		if (!en) begin
			pin_trigger = 1'b0;
		end else if (!typ) begin
			pin_trigger = pol ? lvl : ~lvl;
		end else begin
			pin_trigger = pol ? r : f;
		end
	endfunction

	// ------------------------------------------------------------------
	// Synchronisers and edge detectors
	// ------------------------------------------------------------------
	// Bit positions inside the synchronised vector
	localparam int S_TMR = 0;
	localparam int S_TEMP = 1;
	localparam int S_VOLT = 2;
	localparam int S_ADC = 3;
	localparam int S_PROT = 4;
	localparam int S_BROWN = 9;
	localparam int S_CHG = 10;
	localparam int S_RST = 11;
	localparam int S_SCL = 12;
	localparam int S_SDA = 13;
	localparam int S_PIN1 = 14;
	localparam int S_PIN0 = 15;

	logic [EEI_NSRC-1:0] raw_v;
	logic [EEI_NSRC-1:0] lvl_v;
	logic [EEI_NSRC-1:0] rise_v;
	logic [EEI_NSRC-1:0] fall_v;

	// Each source lands on its named position
	always_comb begin
		raw_v = '0;
		raw_v[S_TMR] = src.tmr_reload;
		raw_v[S_TEMP] = src.temp_stored;
		raw_v[S_VOLT] = src.volt_stored;
		raw_v[S_ADC] = src.adc_on;
		raw_v[S_PROT +: EEI_NPROT] = src.prot_cond;
		raw_v[S_BROWN] = src.brownout;
		raw_v[S_CHG] = src.charger_detect;
		raw_v[S_RST] = src.rst_pin;
		raw_v[S_SCL] = src.link_scl;
		raw_v[S_SDA] = src.link_sda;
		raw_v[S_PIN1] = src.pin1;
		raw_v[S_PIN0] = src.pin0;
	end

	eei_sync_edge #(.W(EEI_NSRC)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.raw(raw_v),
		.level(lvl_v),
		.rise(rise_v),
		.fall(fall_v)
	);

	logic sda_s;
	logic scl_s;
	logic adc_on_s;
	logic [EEI_NPROT-1:0] prot_s;

	assign sda_s = lvl_v[S_SDA];
	assign scl_s = lvl_v[S_SCL];
	assign adc_on_s = lvl_v[S_ADC];
	assign prot_s = lvl_v[S_PROT +: EEI_NPROT];

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	logic [EEI_NFLAG-1:0] mask_q;
	logic [EEI_PC_W-1:0] pin_ctrl_q;
	logic [EEI_AF_W-1:0] alt_fn_q;
	logic [EEI_NFLAG-1:0] flags;
	logic [EEI_NFLAG-1:0] flag_set;
	logic [EEI_NFLAG-1:0] flag_clr;

	logic wr_stb;
	logic rd_stb;
	logic [7:0] wr_off;
	logic [31:0] wr_bits;
	logic ack_q;
	logic [31:0] rdat_q;

	// Access is taken on the edge that raises ack
	assign wr_stb = wb_req.cyc & wb_req.stb & wb_req.we & ~ack_q;
	assign rd_stb = wb_req.cyc & wb_req.stb & ~wb_req.we & ~ack_q;
	assign wr_off = wb_req.adr[7:0];
	assign wr_bits = wb_req.dat & byte_mask(wb_req.sel);

	// Decoded write strobes, one per writable register
	logic [31:0] wr_be;
	logic wr_flags;
	logic wr_mask;
	logic wr_pctl;
	logic wr_alt;

	assign wr_be = byte_mask(wb_req.sel);
	assign wr_flags = wr_stb & reg_hit(wb_req.adr, EEI_OFF_FLAGS);
	assign wr_mask = wr_stb & reg_hit(wb_req.adr, EEI_OFF_MASK);
	assign wr_pctl = wr_stb & reg_hit(wb_req.adr, EEI_OFF_PIN_CTRL) &
		wb_req.sel[0];
	assign wr_alt = wr_stb & reg_hit(wb_req.adr, EEI_OFF_ALT_FN) &
		wb_req.sel[0];

	// All mask bits are kept; the pin-irq mask bits are unused, the pin gates are below
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_q <= EEI_RST_MASK;
		end else if (wr_mask) begin
			mask_q <= (mask_q & ~wr_be[EEI_NFLAG-1:0]) |
				wr_bits[EEI_NFLAG-1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_ctrl_q <= EEI_RST_PIN_CTRL;
		end else if (wr_pctl) begin
			pin_ctrl_q <= wb_req.dat[EEI_PC_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alt_fn_q <= EEI_RST_ALT_FN;
		end else if (wr_alt) begin
			alt_fn_q <= wb_req.dat[EEI_AF_W-1:0];
		end
	end

	assign pin_irq_alt_en = alt_fn_q[1:0];
	assign rst_pin_fn_en = alt_fn_q[EEI_AF_RST] & ~alt_fn_q[EEI_AF_RSTD];

	// Write-one clears of the flag register
	assign flag_clr = wr_flags ? wr_bits[EEI_NFLAG-1:0] : '0;

	// ------------------------------------------------------------------
	// Pin interrupts
	// ------------------------------------------------------------------
	logic [1:0] pin_trig;

	assign pin_trig[0] = pin_trigger(pin_ctrl_q[EEI_PC_EN],
		pin_ctrl_q[EEI_PC_TYPE], pin_ctrl_q[EEI_PC_POL],
		lvl_v[S_PIN0], rise_v[S_PIN0], fall_v[S_PIN0]);
	assign pin_trig[1] = pin_trigger(pin_ctrl_q[EEI_PC_EN + 1],
		pin_ctrl_q[EEI_PC_TYPE + 1], pin_ctrl_q[EEI_PC_POL + 1],
		lvl_v[S_PIN1], rise_v[S_PIN1], fall_v[S_PIN1]);

	// ------------------------------------------------------------------
	// Two-line link watch
	// ------------------------------------------------------------------
	logic both_high;
	logic both_low;
	logic both_high_q;
	logic both_low_q;
	logic link_connect;
	logic link_partial_rise;

	assign both_high = sda_s & scl_s;
	assign both_low = ~sda_s & ~scl_s;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			both_high_q <= 1'b0;
			both_low_q <= 1'b0;
		end else begin
			both_high_q <= both_high;
			both_low_q <= both_low;
		end
	end

	assign link_connect = both_high & ~both_high_q;
	assign link_partial_rise = ~both_low & both_low_q;

	// Disconnect timer: both lines low and the converter running
	logic [EEI_DISC_W-1:0] disc_cnt_q;
	logic disc_done_q;
	logic link_disconnect;
	logic disc_run;

	assign disc_run = both_low & adc_on_s;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			disc_cnt_q <= '0;
		end else if (!disc_run) begin
			disc_cnt_q <= '0;
		end else if (!disc_done_q) begin
			disc_cnt_q <= disc_cnt_q + 1'b1;
		end
	end

	assign link_disconnect = disc_run & ~disc_done_q &
		(disc_cnt_q == EEI_DISC_W'(DISC_CYC - 1));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			disc_done_q <= 1'b0;
		end else if (!disc_run) begin
			disc_done_q <= 1'b0;
		end else if (link_disconnect) begin
			disc_done_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Flag sources
	// ------------------------------------------------------------------
	logic batt_entry;

	// Any condition newly asserted is an entry into a violation
	assign batt_entry = |rise_v[S_PROT +: EEI_NPROT];

	always_comb begin
		flag_set = '0;
		flag_set[EEI_F_PIN0] = pin_trig[0];
		flag_set[EEI_F_PIN1] = pin_trig[1];
		flag_set[EEI_F_CONN] = link_connect;
		flag_set[EEI_F_DISC] = link_disconnect;
		flag_set[EEI_F_PRISE] = link_partial_rise;
		flag_set[EEI_F_CHG] = rise_v[S_CHG];
		flag_set[EEI_F_BROWN] = fall_v[S_BROWN];
		flag_set[EEI_F_BATT] = batt_entry;
		flag_set[EEI_F_VOLT] = rise_v[S_VOLT] & adc_on_s;
		flag_set[EEI_F_TEMP] = rise_v[S_TEMP] & adc_on_s;
		flag_set[EEI_F_TMR] = rise_v[S_TMR];
	end

	// Flags set regardless of mask and alt function; pin flags also need their pin enable
	eei_flag_bank #(.W(EEI_NFLAG)) u_flags (
		.clk(clk),
		.resetn(resetn),
		.set(flag_set),
		.clr(flag_clr),
		.flags(flags)
	);

	// ------------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------------
	logic [EEI_NFLAG-1:0] gate;
	logic [EEI_NFLAG-1:0] pending;
	logic irq_q;

	always_comb begin
		gate = mask_q;
		gate[EEI_F_PIN0] = alt_fn_q[0] & pin_ctrl_q[EEI_PC_EN];
		gate[EEI_F_PIN1] = alt_fn_q[1] &
			pin_ctrl_q[EEI_PC_EN + 1];
	end

	assign pending = flags & gate;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |pending;
		end
	end

	assign irq = irq_q;

	// ------------------------------------------------------------------
	// Wishbone answer
	// ------------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h00000000;
		if (wb_req.adr[31:8] == 24'h000000) begin
			case (wr_off)
				EEI_OFF_FLAGS: rd_mux[EEI_NFLAG-1:0] = flags;
				EEI_OFF_MASK: rd_mux[EEI_NFLAG-1:0] = mask_q;
				EEI_OFF_PIN_CTRL: rd_mux[EEI_PC_W-1:0] = pin_ctrl_q;
				EEI_OFF_ALT_FN: rd_mux[EEI_AF_W-1:0] = alt_fn_q;
				EEI_OFF_PROT: rd_mux[EEI_NPROT-1:0] = prot_s;
				EEI_OFF_LIVE: rd_mux[3:0] = {lvl_v[S_RST], adc_on_s,
					scl_s, sda_s};
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_req.cyc & wb_req.stb & ~ack_q;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdat_q <= 32'h00000000;
		end else if (rd_stb) begin
			rdat_q <= rd_mux;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
endmodule

// File: rtl/eei_pkg.sv
// Constants, field layouts and carrier types of the event flag block.
// Assumes a 25 MHz system clock and a classic Wishbone register port.
//
// How it works
// - one flag register gathers converter, timer, protection, pin and link events.
// - masks, pin settings and reset-pin control live in control registers.
// - pin 0 flag follows its type and polarity when enabled; alt function and enable gate its interrupt.
// - pin 1 flag follows its type and polarity when enabled; alt function and enable gate its interrupt.
// - link connect flag sets when both lines go high after one was low.
// - link disconnect flag sets within 440 ms of both lines low, converter on.
// - partial-rise flag sets when any line rises after all were low.
// - charger attach flag sets on each rise of the charger detect condition.
// - brown-out flag sets on each exit from brown-out, with its own mask.
// - battery event flag sets on each entry into a protection violation.
// - battery events cover over/undervoltage, both overcurrents and short.
// - each battery condition is readable in the protection status register.
// - voltage-ready flag follows each fresh average, never with converter off.
// - temperature-ready flag follows each fresh average, never with converter off.
// - timer reload flag sets each time the timer reloads at its end count.
// - flags set even when their source is masked or its alt function is off; a pin flag needs its pin enable.
// - enable 0 disables; type 0 level, 1 edge; polarity 0 low, 1 high.
package eei_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] EEI_OFF_FLAGS = 8'h00;
	localparam logic [7:0] EEI_OFF_MASK = 8'h04;
	localparam logic [7:0] EEI_OFF_PIN_CTRL = 8'h08;
	localparam logic [7:0] EEI_OFF_ALT_FN = 8'h0C;
	localparam logic [7:0] EEI_OFF_PROT = 8'h10;
	localparam logic [7:0] EEI_OFF_LIVE = 8'h14;

	// ------------------------------------------------------------------
	// Flag bit positions (flags, mask)
	// ------------------------------------------------------------------
	localparam int EEI_NFLAG = 11;
	localparam int EEI_F_PIN0 = 0;
	localparam int EEI_F_PIN1 = 1;
	localparam int EEI_F_CONN = 2;
	localparam int EEI_F_DISC = 3;
	localparam int EEI_F_PRISE = 4;
	localparam int EEI_F_CHG = 5;
	localparam int EEI_F_BROWN = 6;
	localparam int EEI_F_BATT = 7;
	localparam int EEI_F_VOLT = 8;
	localparam int EEI_F_TEMP = 9;
	localparam int EEI_F_TMR = 10;

	// Pin control: enable [1:0], type [3:2], polarity [5:4]
	localparam int EEI_PC_EN = 0;
	localparam int EEI_PC_TYPE = 2;
	localparam int EEI_PC_POL = 4;
	localparam int EEI_PC_W = 6;
	// Alt function: pin0 [0], pin1 [1], reset pin [2], reset disable [3]
	localparam int EEI_AF_RST = 2;
	localparam int EEI_AF_RSTD = 3;
	localparam int EEI_AF_W = 4;
	localparam int EEI_NPROT = 5;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [EEI_NFLAG-1:0] EEI_RST_FLAGS = 11'h000;
	localparam logic [EEI_NFLAG-1:0] EEI_RST_MASK = 11'h000;
	localparam logic [EEI_PC_W-1:0] EEI_RST_PIN_CTRL = 6'h00;
	localparam logic [EEI_AF_W-1:0] EEI_RST_ALT_FN = 4'h4;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int EEI_CLK_HZ = 25000000;
	localparam int EEI_DISC_MS = 440;
	localparam int EEI_DISC_CYC = EEI_CLK_HZ / 1000 * EEI_DISC_MS;
	localparam int EEI_DISC_W = 24;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} eei_wb_req_t;

	typedef struct packed {
		logic pin0;
		logic pin1;
		logic link_sda;
		logic link_scl;
		logic rst_pin;
		logic charger_detect;
		logic brownout;
		logic [EEI_NPROT-1:0] prot_cond;
		logic adc_on;
		logic volt_stored;
		logic temp_stored;
		logic tmr_reload;
	} eei_src_t;

	localparam int EEI_NSRC = 16;

endpackage

// File: rtl/eei_sync_edge.sv
// Two-stage synchroniser with rise and fall detection per bit.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ps
module eei_sync_edge #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Raw and conditioned signals
	input wire logic [W-1:0] raw,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule

// File: rtl/eei_flag_bank.sv
// Sticky flag bank: hardware sets, software clears with write-one.
// Assumes set and clear are one-cycle pulses on clk.
`timescale 1ns/1ps
module eei_flag_bank #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Set and clear
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	// Flags
	output logic [W-1:0] flags
);
	logic [W-1:0] flags_q;

	// A set in the clearing cycle wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= '0;
		end else begin
			flags_q <= (flags_q & ~clr) | set;
		end
	end

	assign flags = flags_q;
endmodule

// File: tb/eei_event_flags_properties.sv
// Port checker for the event flag block.
// Assumes one clock domain and a classic Wishbone master.
`timescale 1ns/1ps
module eei_event_flags_chk
	import eei_pkg::*;
#(
	parameter int DISC_CYC = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus
	input wire eei_pkg::eei_wb_req_t wb_req,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Sources and outputs
	input wire eei_pkg::eei_src_t src,
	input wire logic [1:0] pin_irq_alt_en,
	input wire logic rst_pin_fn_en,
	input wire logic irq
);
	logic req;
	logic wr;
	assign req = wb_req.cyc & wb_req.stb & !wb_ack_o;
	assign wr = req & wb_req.we;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	a_ack_next: assert property (req |=> wb_ack_o)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_idle: assert property (
		!(wb_req.cyc & wb_req.stb) |=> !wb_ack_o)
		else $error("ack without request");
	a_unmapped_zero: assert property (req && !wb_req.we &&
		wb_req.adr[31:8] != 24'h0 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_prot_width: assert property (req && !wb_req.we &&
		wb_req.adr == 32'h10 |=> wb_dat_o[31:5] == 27'h0)
		else $error("protection status too wide");
	a_irq_hold: assert property (irq && !wr && !$past(wr) |=> irq)
		else $error("irq dropped without write");
	a_alt_write: assert property (
		wr && wb_req.adr == 32'h0C && wb_req.sel[0] |=>
		pin_irq_alt_en == $past(wb_req.dat[1:0]) &&
		rst_pin_fn_en == ($past(wb_req.dat[2]) & !$past(wb_req.dat[3])))
		else $error("alt function write wrong");
	a_alt_stable: assert property (!$past(wr) |->
		$stable(pin_irq_alt_en) && $stable(rst_pin_fn_en))
		else $error("alt function changed alone");
	c_write: cover property (wr);
	c_irq_rise: cover property ($rose(irq));
	c_irq_fall: cover property ($fell(irq));
endmodule

bind eei_event_flags eei_event_flags_chk #(.DISC_CYC(DISC_CYC)) u_chk (
	.clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .src(src), .pin_irq_alt_en(pin_irq_alt_en),
	.rst_pin_fn_en(rst_pin_fn_en), .irq(irq));

// File: tb/eei_src_model.sv
// Model of the event sources: pins, link lines, analog and timer side.
// Assumes the bench calls put() to change the source levels.
`timescale 1ns/1ps
module eei_src_model
	import eei_pkg::*;
(
	// Clock
	input wire logic clk,
	// Source levels
	output eei_pkg::eei_src_t src
);
	initial src = '0;
	task automatic put(input eei_src_t v);
		eei_src_t w;
		w = v;
		// A converter that is off stores no averages
		if (!w.adc_on) begin
			w.volt_stored = 1'b0;
			w.temp_stored = 1'b0;
		end
		@(posedge clk);
		src <= w;
	endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the event flag block.
// Assumes the source model and the port checker beside the design.
`timescale 1ns/1ps
module testbench;
	import eei_pkg::*;
	localparam int DISC = 20;
	logic clk;
	logic resetn;
	eei_wb_req_t wb_req;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	eei_src_t src;
	eei_src_t s;
	logic [1:0] pin_irq_alt_en;
	logic rst_pin_fn_en;
	logic irq;
	logic [31:0] q;
	logic [23:0] hi;
	logic [1:0] pv;
	int errors;
	int compares;

	eei_event_flags #(.DISC_CYC(DISC)) uut (.clk(clk), .resetn(resetn),
		.wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.src(src), .pin_irq_alt_en(pin_irq_alt_en),
		.rst_pin_fn_en(rst_pin_fn_en), .irq(irq));
	eei_src_model sm (.clk(clk), .src(src));

	always #20 clk = ~clk;
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic end_sim();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string nm);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		wb_req <= '{adr: {hi, a}, dat: d, sel: 4'hF, we: we, cyc: 1'b1,
			stb: 1'b1};
		@(posedge clk);
		while (wb_ack_o !== 1'b1) @(posedge clk);
		q = wb_dat_o;
		wb_req.cyc <= 1'b0;
		wb_req.stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input string nm);
		wb(1'b0, a, 32'h0);
		chk(q, exp, nm);
	endtask
	// Waits for an event to land, checks it, clears it, checks it is gone
	task automatic ev(input logic [10:0] exp, input logic ie);
		repeat (6) @(posedge clk);
		rd(EEI_OFF_FLAGS, {21'h0, exp}, "flags");
		chk({31'h0, irq}, {31'h0, ie}, "irq");
		wb(1'b1, EEI_OFF_FLAGS, {21'h0, exp});
		rd(EEI_OFF_FLAGS, 32'h0, "cleared");
		chk({31'h0, irq}, 32'h0, "irq_clr");
	endtask
	task automatic setpin(input int i, input logic v);
		pv[i] = v;
		s.pin0 = pv[0];
		s.pin1 = pv[1];
		sm.put(s);
	endtask
	task automatic pin(input int i, input logic t, p, en,
		input logic [10:0] exp);
		logic [31:0] c;
		c = 32'h0;
		c[EEI_PC_EN + i] = en;
		c[EEI_PC_TYPE + i] = t;
		c[EEI_PC_POL + i] = p;
		wb(1'b1, EEI_OFF_PIN_CTRL, c);
		setpin(i, !p);
		repeat (6) @(posedge clk);
		wb(1'b1, EEI_OFF_FLAGS, 32'h7FF);
		setpin(i, p);
		repeat (6) @(posedge clk);
		setpin(i, !p);
		ev(exp, |exp);
	endtask
	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		wb_req = '0;
		hi = 24'h0;
		pv = 2'b00;
		s = '0;
		errors = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		chk({31'h0, rst_pin_fn_en}, 32'h1, "rst_fn");
		chk({30'h0, pin_irq_alt_en}, 32'h0, "alt_en");
		rd(EEI_OFF_FLAGS, 32'h0, "flags_rst");
		rd(EEI_OFF_MASK, 32'h0, "mask_rst");
		rd(EEI_OFF_PIN_CTRL, 32'h0, "ctrl_rst");
		rd(EEI_OFF_ALT_FN, 32'h4, "alt_rst");
		rd(8'h18, 32'h0, "unmapped");
		hi = 24'h1;
		rd(EEI_OFF_ALT_FN, 32'h0, "high_adr");
		hi = 24'h0;
		s.link_sda = 1'b1;
		s.link_scl = 1'b1;
		s.adc_on = 1'b1;
		s.rst_pin = 1'b1;
		sm.put(s);
		ev(11'h014, 1'b0);
		rd(EEI_OFF_LIVE, 32'hF, "live");
		wb(1'b1, EEI_OFF_MASK, 32'h7FF);
		rd(EEI_OFF_MASK, 32'h7FF, "mask");
		wb(1'b1, EEI_OFF_PROT, 32'h1F);
		rd(EEI_OFF_PROT, 32'h0, "prot_ro");
		s.charger_detect = 1'b1;
		sm.put(s);
		ev(11'h020, 1'b1);
		s.brownout = 1'b1;
		sm.put(s);
		s.brownout = 1'b0;
		sm.put(s);
		ev(11'h040, 1'b1);
		for (int k = 0; k < EEI_NPROT; k++) begin
			s.prot_cond = 5'h01 << k;
			sm.put(s);
			ev(11'h080, 1'b1);
			rd(EEI_OFF_PROT, 32'h1 << k, "prot");
			s.prot_cond = 5'h00;
			sm.put(s);
		end
		for (int k = 0; k < 3; k++) begin
			s[k] = 1'b1;
			sm.put(s);
			s[k] = 1'b0;
			sm.put(s);
			ev(11'h400 >> k, 1'b1);
		end
		s.link_sda = 1'b0;
		s.link_scl = 1'b0;
		sm.put(s);
		repeat (DISC + 4) @(posedge clk);
		ev(11'h008, 1'b1);
		s.link_sda = 1'b1;
		sm.put(s);
		ev(11'h010, 1'b1);
		s.link_scl = 1'b1;
		sm.put(s);
		ev(11'h004, 1'b1);
		s.adc_on = 1'b0;
		s.link_sda = 1'b0;
		s.link_scl = 1'b0;
		sm.put(s);
		repeat (DISC + 10) @(posedge clk);
		ev(11'h000, 1'b0);
		s.adc_on = 1'b1;
		s.link_sda = 1'b1;
		s.link_scl = 1'b1;
		sm.put(s);
		ev(11'h014, 1'b1);
		wb(1'b1, EEI_OFF_MASK, 32'h0);
		s.charger_detect = 1'b0;
		sm.put(s);
		s.charger_detect = 1'b1;
		sm.put(s);
		ev(11'h020, 1'b0);
		wb(1'b1, EEI_OFF_MASK, 32'h7FF);
		wb(1'b1, EEI_OFF_ALT_FN, 32'h7);
		chk({30'h0, pin_irq_alt_en}, 32'h3, "alt_on");
		for (int i = 0; i < 2; i++)
			for (int m = 0; m < 4; m++)
				pin(i, m[1], m[0], 1'b1, 11'h1 << i);
		pin(0, 1'b1, 1'b1, 1'b0, 11'h000);
		wb(1'b1, EEI_OFF_ALT_FN, 32'hC);
		chk({31'h0, rst_pin_fn_en}, 32'h0, "rst_fn_off");
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_sim();
	end
endmodule
